// *** hw/cpu_idle_map.vh ***
// Purpose: Offsets, field positions, reset values and patterns of the CPU domain idle gating block
// Assumes: Wishbone byte addressing, one 32-bit word per register, four bytes apart
// Notes: Definitions only
`ifndef CPU_IDLE_MAP_VH
`define CPU_IDLE_MAP_VH
`define ADDR_IDLE_REQUEST_CONFIG 4'h0
`define ADDR_IDLE_APPLIED_STATE 4'h4
`define ADDR_INT_FLAG_REG_ONE 4'h8
`define ADDR_INT_MASK 4'hc
`define BIT_CORE 0
`define BIT_DATA_PORT 5
`define BIT_IO_PORT 6
`define BIT_DMA_PORT 7
`define BIT_FETCH_PORT 8
`define BIT_ACCEL 9
`define FIXED_LSB 1
`define FIXED_MSB 4
`define FIXED_PATTERN 4'h7
`define CFG_RESET 16'h0000
`define STATE_RESET 16'h0000
`define CFG_WMASK 16'h03ff
`define STATE_MASK 16'h03e1
`define WAKE_MASK 16'h0161
`define IRQ_BUS_FAULT 0
`define IRQ_APPLIED 1
`define IRQ_WIDTH 2
`endif

// *** hw/idle_check.v ***
// Purpose: Decides whether an idle request word is a legal configuration
// Assumes: Combinational, pure function of the word
// Notes: Used by the gating top once per idle instruction
`timescale 1ns/1ns
`include "cpu_idle_map.vh"
module idle_check
(
    input wire [15:0] cfg_i,
    output wire valid_o
);
    wire any_port;
    wire cpu_dep;
    wire bad_fixed;
    wire bad_dep;
    assign any_port = cfg_i[`BIT_DATA_PORT] | cfg_i[`BIT_IO_PORT] | cfg_i[`BIT_FETCH_PORT]
        | cfg_i[`BIT_DMA_PORT];
    assign cpu_dep = cfg_i[`BIT_DATA_PORT] | cfg_i[`BIT_IO_PORT] | cfg_i[`BIT_FETCH_PORT];
    assign bad_fixed = any_port & (cfg_i[`FIXED_MSB:`FIXED_LSB] != `FIXED_PATTERN);
    assign bad_dep = cpu_dep & ~cfg_i[`BIT_CORE];
    assign valid_o = ~(bad_fixed | bad_dep);
endmodule // idle_check

// *** hw/cpu_domain_idle_gating.v ***
// Purpose: Idle gating control of the CPU clock domain with a Wishbone register port
// Assumes: One 20 MHz clock, synchronous active-high reset, inputs synchronous to clk_i
// Notes: Gate enables are active high meaning the sub-domain is disabled
//
// Overview of operation
// - Config bit 9 set gates the FFT accelerator on the next idle instruction.
// - Config bit 8 set disables the instruction fetch port after the idle instruction.
// - Config bit 7 set disables the DMA memory port after the idle instruction.
// - Config bit 6 set disables the I/O space port after the idle instruction.
// - Config bit 5 set disables the data memory port after the idle instruction.
// - Config bit 0 set stops the CPU clock after the idle instruction.
// - The read-only status register shows bits 9,8,7,6,5,0 as applied idle state.
// - An invalid idle sets the bus fault flag and changes no gating.
// - Any port idle bit set with the fixed field not 0111 is invalid.
// - Data, I/O or fetch port idle bit set without the CPU bit is invalid.
// - Writing the config does nothing until the idle instruction copies it to status.
// - A core interrupt on core_int_i, which no mask gates, clears status bits 0, 5, 6 and 8 only.
`timescale 1ns/1ns
`include "cpu_idle_map.vh"
module cpu_domain_idle_gating
(
    input wire clk_i,
    input wire rst_i,
    input wire [31:0] adr_i,
    input wire [31:0] dat_i,
    output reg [31:0] dat_o,
    input wire [3:0] sel_i,
    input wire we_i,
    input wire cyc_i,
    input wire stb_i,
    output reg ack_o,
    output reg err_o,
    input wire idle_instr_i,
    input wire core_int_i,
    output reg accel_idle_state_o,
    output reg fetch_port_idle_state_o,
    output reg dma_mem_port_idle_state_o,
    output reg io_space_port_idle_state_o,
    output reg data_mem_port_idle_state_o,
    output reg core_idle_state_o,
    output reg bus_fault_flag_o,
    output reg irq_o
);
    reg [15:0] idle_request_config;
    reg [15:0] idle_applied_state;
    reg [`IRQ_WIDTH-1:0] int_flag_reg_one;
    reg [`IRQ_WIDTH-1:0] int_mask;
    reg [15:0] next_config;
    reg [15:0] next_state;
    reg [`IRQ_WIDTH-1:0] next_flags;
    reg [`IRQ_WIDTH-1:0] next_mask;
    reg [31:0] next_rdata;
    wire cfg_valid;
    wire req;
    wire wr;
    wire rd;
    wire hit;
    wire wr_cfg;
    wire wr_flags;
    wire wr_mask;
    wire idle_apply;
    wire idle_reject;
    wire [15:0] cfg_wmask;

    // One decode for the write selects; reads decode adr_i[3:0] in their own case
    function reg_at;
        input [31:0] adr;
        input [3:0] offset;
        begin
            reg_at = (adr[31:4] == 28'h0000000) && (adr[3:0] == offset);
        end
    endfunction

    assign req = cyc_i & stb_i & ~ack_o & ~err_o;
    assign wr = req & we_i;
    assign rd = req & ~we_i;
    assign hit = (adr_i[31:4] == 28'h0000000);
    assign wr_cfg = wr & reg_at(adr_i, `ADDR_IDLE_REQUEST_CONFIG);
    assign wr_flags = wr & sel_i[0] & reg_at(adr_i, `ADDR_INT_FLAG_REG_ONE);
    assign wr_mask = wr & sel_i[0] & reg_at(adr_i, `ADDR_INT_MASK);
    assign idle_apply = idle_instr_i & cfg_valid;
    assign idle_reject = idle_instr_i & ~cfg_valid;
    assign cfg_wmask = `CFG_WMASK;

    idle_check u_check
    (
        .cfg_i(idle_request_config),
        .valid_o(cfg_valid)
    );

    // Status: copy on valid idle, wake on interrupt; wake wins so the core is never lost asleep
    always @*
    begin
        next_state = idle_applied_state;
        if (idle_apply)
        begin
            next_state = idle_request_config & `STATE_MASK;
        end
        if (core_int_i)
        begin
            next_state = next_state & ~`WAKE_MASK;
        end
    end

    // Flags: hardware set beats a write-one clear in the same cycle
    always @*
    begin
        next_flags = int_flag_reg_one;
        if (wr_flags)
        begin
            next_flags = next_flags & ~dat_i[`IRQ_WIDTH-1:0];
        end
        if (idle_reject)
        begin
            next_flags[`IRQ_BUS_FAULT] = 1'b1;
        end
        if (idle_apply)
        begin
            next_flags[`IRQ_APPLIED] = 1'b1;
        end
    end

    // Only lanes 0 and 1 exist; reserved bits 15-10 are never stored, so they read back zero
    always @*
    begin
        next_config = idle_request_config;
        if (wr_cfg && sel_i[0])
        begin
            next_config[7:0] = dat_i[7:0];
        end
        if (wr_cfg && sel_i[1])
        begin
            next_config[15:8] = dat_i[15:8] & cfg_wmask[15:8];
        end
    end

    always @*
    begin
        next_mask = int_mask;
        if (wr_mask)
        begin
            next_mask = dat_i[`IRQ_WIDTH-1:0];
        end
    end

    // Unmapped offsets inside the window answer zero instead of an error; status is read-only
    always @*
    begin
        next_rdata = 32'h00000000;
        if (rd && hit)
        begin
            case (adr_i[3:0])
                `ADDR_IDLE_REQUEST_CONFIG: next_rdata = {16'h0000, idle_request_config};
                `ADDR_IDLE_APPLIED_STATE: next_rdata = {16'h0000, idle_applied_state};
                `ADDR_INT_FLAG_REG_ONE: next_rdata = {{(32-`IRQ_WIDTH){1'b0}}, int_flag_reg_one};
                `ADDR_INT_MASK: next_rdata = {{(32-`IRQ_WIDTH){1'b0}}, int_mask};
                default: next_rdata = 32'h00000000;
            endcase
        end
    end

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            idle_request_config <= `CFG_RESET;
            int_mask <= {`IRQ_WIDTH{1'b0}};
        end
        else
        begin
            idle_request_config <= next_config;
            int_mask <= next_mask;
        end
    end

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            idle_applied_state <= `STATE_RESET;
            int_flag_reg_one <= {`IRQ_WIDTH{1'b0}};
        end
        else
        begin
            // Rejected idle leaves next_state equal to the old value
            idle_applied_state <= next_state;
            int_flag_reg_one <= next_flags;
        end
    end

    // One flop per gate enable, loaded from the same next value as the status register
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            accel_idle_state_o <= 1'b0;
        end
        else
        begin
            accel_idle_state_o <= next_state[`BIT_ACCEL];
        end
    end

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            fetch_port_idle_state_o <= 1'b0;
        end
        else
        begin
            fetch_port_idle_state_o <= next_state[`BIT_FETCH_PORT];
        end
    end

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            dma_mem_port_idle_state_o <= 1'b0;
        end
        else
        begin
            dma_mem_port_idle_state_o <= next_state[`BIT_DMA_PORT];
        end
    end

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            io_space_port_idle_state_o <= 1'b0;
        end
        else
        begin
            io_space_port_idle_state_o <= next_state[`BIT_IO_PORT];
        end
    end

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            data_mem_port_idle_state_o <= 1'b0;
        end
        else
        begin
            data_mem_port_idle_state_o <= next_state[`BIT_DATA_PORT];
        end
    end

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            core_idle_state_o <= 1'b0;
        end
        else
        begin
            core_idle_state_o <= next_state[`BIT_CORE];
        end
    end

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            bus_fault_flag_o <= 1'b0;
            irq_o <= 1'b0;
        end
        else
        begin
            bus_fault_flag_o <= next_flags[`IRQ_BUS_FAULT];
            // Next mask as well, so a mask write shows on irq_o without a cycle of lag
            irq_o <= |(next_flags & next_mask);
        end
    end

    // One registered answer per request; the req term stops an ack in the cycle right after an ack
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_o <= 1'b0;
            err_o <= 1'b0;
        end
        else
        begin
            ack_o <= req & hit;
            err_o <= req & ~hit;
        end
    end

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            dat_o <= 32'h00000000;
        end
        else
        begin
            dat_o <= next_rdata;
        end
    end
endmodule // cpu_domain_idle_gating

// *** testbench/cpu_domain_idle_gating_monitor.sv ***
// Purpose: Port checker of the idle gating block
// Assumes: Sync active-high reset
// Notes: Request validity is judged by the bench
`timescale 1ns/1ns
module cpu_domain_idle_gating_monitor
(
    input wire clk_i,
    input wire rst_i,
    input wire [31:0] adr_i,
    input wire cyc_i,
    input wire stb_i,
    input wire ack_o,
    input wire err_o,
    input wire idle_instr_i,
    input wire core_int_i,
    input wire accel_idle_state_o,
    input wire fetch_port_idle_state_o,
    input wire dma_mem_port_idle_state_o,
    input wire io_space_port_idle_state_o,
    input wire data_mem_port_idle_state_o,
    input wire core_idle_state_o,
    input wire bus_fault_flag_o
);
    wire [5:0] st = {accel_idle_state_o, fetch_port_idle_state_o, dma_mem_port_idle_state_o,
        io_space_port_idle_state_o, data_mem_port_idle_state_o, core_idle_state_o};
    wire req = cyc_i && stb_i && !ack_o && !err_o;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_next_cycle: assert property (req && adr_i[31:4] == 28'h0 |=> ack_o && !err_o)
        else $error("ack missing");
    a_ack_one_pulse: assert property (ack_o |=> !ack_o) else $error("ack too long");
    a_err_high_addr: assert property (req && adr_i[31:4] != 28'h0 |=> err_o && !ack_o)
        else $error("err missing");
    a_port_needs_core: assert property (st[4] || st[2] || st[1] |-> st[0])
        else $error("port idle without core idle");
    a_state_needs_cause: assert property (!idle_instr_i && !core_int_i |=> $stable(st))
        else $error("gating changed alone");
    a_wake_ports: assert property (core_int_i |=> !st[4] && st[2:0] == 3'h0)
        else $error("wake left a port idle");
    a_wake_keeps: assert property (core_int_i && !idle_instr_i |=>
        $stable({st[5], st[3]}))
        else $error("wake touched accel or dma");
    a_fault_no_effect: assert property ($rose(bus_fault_flag_o) |->
        $past(idle_instr_i) && ($past(core_int_i) || $stable(st)))
        else $error("fault without idle or with gating change");
endmodule // cpu_domain_idle_gating_monitor
bind cpu_domain_idle_gating cpu_domain_idle_gating_monitor i_monitor (.clk_i(clk_i),
    .rst_i(rst_i), .adr_i(adr_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .err_o(err_o),
    .idle_instr_i(idle_instr_i), .core_int_i(core_int_i), .accel_idle_state_o(accel_idle_state_o),
    .fetch_port_idle_state_o(fetch_port_idle_state_o), .core_idle_state_o(core_idle_state_o),
    .dma_mem_port_idle_state_o(dma_mem_port_idle_state_o), .bus_fault_flag_o(bus_fault_flag_o),
    .io_space_port_idle_state_o(io_space_port_idle_state_o),
    .data_mem_port_idle_state_o(data_mem_port_idle_state_o));

// *** testbench/cpu_core_model.sv ***
// Purpose: Core model issuing idle instructions and wake interrupts
// Assumes: Called just after a rising edge
// Notes: Gap lets the core issue late
`timescale 1ns/1ns
module cpu_core_model
(
    input wire clk_i,
    output logic idle_instr_o = 1'b0,
    output logic core_int_o = 1'b0
);
    task exec_idle(input int gap);
        repeat (gap) @(posedge clk_i);
        idle_instr_o <= 1'b1;
        @(posedge clk_i);
        idle_instr_o <= 1'b0;
    endtask
    task wake();
        core_int_o <= 1'b1;
        @(posedge clk_i);
        core_int_o <= 1'b0;
    endtask
endmodule // cpu_core_model

// *** testbench/test_cpu_domain_idle_gating.sv ***
// Purpose: Random and corner tests of the idle gating block
// Assumes: Flags at 0x8, mask at 0xc
// Notes: Odd rounds after the five corner rounds force a legal fixed field
`timescale 1ns/1ns
module test_cpu_domain_idle_gating;
    logic clk_i = 1'b0, rst_i = 1'b1, we_i = 1'b0, cyc_i = 1'b0, stb_i = 1'b0;
    logic [31:0] adr_i = 32'h0, dat_i = 32'h0, dat_o, q;
    logic [3:0] sel_i = 4'h0;
    logic ack_o, err_o, idle_instr_i, core_int_i, irq_o, bus_fault_flag_o, e, ok;
    logic [5:0] st;
    logic [15:0] c, s;
    logic [15:0] corner [5] = '{16'h03ef, 16'h0040, 16'h004f, 16'h0280, 16'h0201};
    int seed = 32'h5e95, miscompares = 0, samples_checked = 0, n;
    always #25 clk_i = ~clk_i;
    cpu_core_model i_core (.clk_i(clk_i), .idle_instr_o(idle_instr_i), .core_int_o(core_int_i));
    cpu_domain_idle_gating i_dut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i),
        .dat_o(dat_o), .sel_i(sel_i), .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
        .err_o(err_o), .idle_instr_i(idle_instr_i), .core_int_i(core_int_i), .irq_o(irq_o),
        .accel_idle_state_o(st[5]), .fetch_port_idle_state_o(st[4]), .core_idle_state_o(st[0]),
        .dma_mem_port_idle_state_o(st[3]), .io_space_port_idle_state_o(st[2]),
        .data_mem_port_idle_state_o(st[1]), .bus_fault_flag_o(bus_fault_flag_o));
    task chk(input logic [31:0] got, input logic [31:0] want);
        samples_checked++;
        if (got !== want)
        begin
            miscompares++;
            $display("MISMATCH %0t got %h want %h", $time, got, want);
        end
    endtask
    task finish_test();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task wb(input logic w, input logic [31:0] a, input logic [31:0] d);
        n = 0;
        {cyc_i, stb_i, we_i, sel_i} <= {2'b11, w, 4'h3};
        adr_i <= a;
        dat_i <= d;
        do @(posedge clk_i); while (ack_o !== 1'b1 && err_o !== 1'b1 && ++n < 16);
        q = dat_o;
        e = err_o;
        chk(n < 16, 1'b1);
        if (n >= 16)
            finish_test();
        {cyc_i, stb_i} <= 2'b00;
        @(posedge clk_i);
    endtask
    initial
    begin
        repeat (20000) @(posedge clk_i);
        miscompares++;
        finish_test();
    end
    initial
    begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(1'b0, 32'h0, 32'h0);
        chk(q, 32'h0);
        wb(1'b0, 32'h1, 32'h0);
        chk(q, 32'h0);
        wb(1'b0, 32'h10, 32'h0);
        chk(e, 1'b1);
        $display("bus access test done");
        wb(1'b1, 32'hc, 32'h3);
        s = 16'h0;
        for (int i = 0; i < 30; i++)
        begin
            c = i < 5 ? corner[i] : $random(seed) & 16'h03ff;
            if (i > 4 && i[0])
                c[4:1] = 4'h7; // Legal pattern, core set with io
            if (i > 4 && i[0] && c[6])
                c[0] = 1'b1;
            wb(1'b1, 32'h8, 32'h3);
            wb(1'b1, 32'h0, {16'h0, c});
            chk(irq_o, 1'b0);
            wb(1'b0, 32'h0, 32'h0);
            chk(q, c);
            wb(1'b0, 32'h4, 32'h0);
            chk(q, s);
            i_core.exec_idle($unsigned($random(seed)) % 3);
            ok = !((|c[8:5] && c[4:1] != 4'h7) || ((c[5] | c[6] | c[8]) && !c[0]));
            s = ok ? c & 16'h03e1 : s;
            wb(1'b0, 32'h4, 32'h0);
            chk(q, s);
            chk(st, {s[9:5], s[0]});
            chk({bus_fault_flag_o, irq_o}, {!ok, 1'b1});
            if (i % 3 == 0)
            begin
                i_core.wake();
                s = s & ~16'h0161;
                wb(1'b0, 32'h4, 32'h0);
                chk(q, s);
            end
            $display("idle round %0d done", i);
        end
        wb(1'b1, 32'hc, 32'h0);
        wb(1'b1, 32'h8, 32'h3);
        wb(1'b1, 32'h0, 32'h0040);
        i_core.exec_idle(0);
        wb(1'b0, 32'h8, 32'h0);
        chk({q[0], irq_o}, 2'b10);
        $display("masked fault test done");
        finish_test();
    end
endmodule // test_cpu_domain_idle_gating
